// *** inc/anx_pkg.sv ***
// Package with register map, field positions, states and timing constants
// ****************************************
// ****************************************
package anx_pkg;
	localparam logic [4:0] REG_BASIC_CONTROL  = 5'h00;
	localparam logic [4:0] REG_BASIC_STATUS   = 5'h01;
	localparam logic [4:0] REG_LOCAL_ADVERT   = 5'h04;
	localparam logic [4:0] REG_PARTNER_AB     = 5'h05;
	localparam logic [4:0] REG_EXPANSION      = 5'h06;
	localparam logic [4:0] REG_NEXT_PAGE_TX   = 5'h07;
	localparam logic [4:0] REG_XCVR_CONTROL   = 5'h10;

	localparam int BIT_RESTART      = 9;
	localparam int BIT_NEG_ENABLE   = 12;
	localparam int BIT_PAUSE        = 10;
	localparam int BIT_ASYM_PAUSE   = 11;
	localparam int BIT_NEG_COMPLETE = 5;
	localparam int BIT_LINK_STATUS  = 2;
	localparam int BIT_PARTNER_NEG  = 0;
	localparam int BIT_PD_FAULT     = 4;
	localparam int BIT_PARTNER_10   = 5;
	localparam int BIT_PARTNER_100  = 7;
	localparam int BIT_XOVER_AUTO   = 6;
	localparam int BIT_XOVER_FORCE  = 5;

	localparam logic [4:0]  SELECTOR_8023   = 5'h01;
	localparam logic [15:0] CONTROL_RESET   = 16'h1000;
	localparam logic [15:0] ADVERT_RESET    = 16'h01e1;
	localparam logic [15:0] STATUS_ABILITY  = 16'h7948;
	localparam logic [15:0] XCVR_RESET      = 16'h0040;
	localparam logic [15:0] NEXT_PAGE_RESET = 16'h2001;

	// Resolved speeds
	typedef enum logic [1:0]
	{
		SPD_10   = 2'b00,
		SPD_100  = 2'b01,
		SPD_1000 = 2'b10,
		SPD_NONE = 2'b11
	} anx_speed_type;

	typedef enum logic [2:0]
	{
		ST_DISABLED = 3'b000,
		ST_BREAK    = 3'b001,
		ST_XOVER    = 3'b010,
		ST_EXCHANGE = 3'b011,
		ST_LINK_UP  = 3'b100
	} anx_state_type;

	// Timing figures
	localparam int CLK_MHZ          = 100;
	localparam int BREAK_LINK_MS    = 1200;
	localparam int XOVER_SLOT_MS    = 62;
	localparam int NEG_TIME_MS      = 2500;
	localparam int BREAK_LINK_CYC   = BREAK_LINK_MS * CLK_MHZ * 1000;
	localparam int XOVER_SLOT_CYC   = XOVER_SLOT_MS * CLK_MHZ * 1000;
	localparam int NEG_TIME_CYC     = NEG_TIME_MS * CLK_MHZ * 1000;
endpackage

// *** rtl/anx_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module anx_sync #(
	parameter int WIDTH = 1
)(
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	initial
	begin
		if (WIDTH < 1) $error("anx_sync: WIDTH must be positive");
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// *** rtl/anx_xover.sv ***
// Pair crossover resolver: hunts for link by alternating pair assignment
`timescale 1ns/1ps
`default_nettype none
module anx_xover #(
	parameter int SLOT_CYC = anx_pkg::XOVER_SLOT_CYC
)(
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic auto_en,
	input  wire logic force_crossed,
	input  wire logic energy_seen,
	output logic      crossed,
	output logic      resolved
);
	import anx_pkg::*;

	logic [31:0] slot_q;

	initial
	begin
		if (SLOT_CYC < 1) $error("anx_xover: SLOT_CYC must be positive");
	end

	// Works from the receive energy, auto_en and force_crossed alone, so speed or negotiation mode is irrelevant
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			slot_q   <= '0;
			crossed  <= 1'b0;
			resolved <= 1'b0;
		end
		else if (!auto_en)
		begin
			slot_q   <= '0;
			crossed  <= force_crossed;
			resolved <= 1'b1;
		end
		else if (energy_seen)
		begin
			slot_q   <= '0;
			resolved <= 1'b1;
		end
		else if (slot_q == 32'(SLOT_CYC - 1))
		begin
			slot_q   <= '0;
			crossed  <= ~crossed;
			resolved <= 1'b0;
		end
		else
		begin
			slot_q   <= slot_q + 32'h1;
			resolved <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** rtl/anx_core.sv ***
// Negotiation control, status registers and crossover control
`timescale 1ns/1ps
`default_nettype none
module anx_core #(
	parameter int BREAK_CYC = anx_pkg::BREAK_LINK_CYC,
	parameter int NEG_CYC   = anx_pkg::NEG_TIME_CYC,
	parameter int SLOT_CYC  = anx_pkg::XOVER_SLOT_CYC
)(
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	// Management register port
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	input  wire logic [4:0]            reg_addr,
	input  wire logic [15:0]           reg_wdata,
	output logic      [15:0]           reg_rdata,
	// Straps, sampled at reset release
	input  wire logic                  neg_disable_strap,
	input  wire logic                  crossover_disable_strap,
	input  wire logic                  forced_pair_select_strap,
	input  wire logic                  multiport_node,
	// Line side, from the receivers
	input  wire logic                  partner_page_valid,
	input  wire logic [15:0]           partner_page,
	input  wire logic                  partner_master_seed,
	input  wire logic                  rx_link_10,
	input  wire logic                  rx_link_100,
	input  wire logic                  rx_energy,
	input  wire logic                  partner_np_valid,
	// Line side, to the transmitters
	output logic                       tx_quiet,
	output logic                       flp_send,
	output logic      [15:0]           flp_page,
	output logic                       pairs_crossed,
	output logic                       link_up,
	output anx_pkg::anx_speed_type     link_speed,
	output logic                       full_duplex,
	output logic                       gig_master
);
	import anx_pkg::*;

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [25:0] pin_raw;
	logic [25:0] pin_s;
	logic       strap_neg_off;
	logic       strap_xover_off;
	logic       strap_force_x;
	logic       multi_s;
	logic       page_v_s;
	logic       link10_s;
	logic       link100_s;
	logic       energy_s;
	logic       np_v_s;
	logic       seed_s;
	logic [15:0] page_s;

	// Page word shares the valid's latency, so it is settled when taken
	assign pin_raw = {partner_page, multiport_node, partner_master_seed,
		neg_disable_strap, crossover_disable_strap,
		forced_pair_select_strap, partner_page_valid, rx_link_10,
		rx_link_100, rx_energy, partner_np_valid};

	anx_sync #(.WIDTH(26)) u_sync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in (pin_raw),
		.sync_out (pin_s)
	);

	assign page_v_s  = pin_s[4];
	assign link10_s  = pin_s[3];
	assign link100_s = pin_s[2];
	assign energy_s  = pin_s[1];
	assign np_v_s    = pin_s[0];
	assign seed_s    = pin_s[8];
	assign page_s    = pin_s[25:10];

	// Straps caught once, a few cycles after reset release
	logic [1:0] strap_cnt_q;
	logic       strap_neg_q;
	logic       strap_xo_q;
	logic       strap_fx_q;
	logic       multi_q;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			strap_cnt_q <= '0;
			strap_neg_q <= 1'b0;
			strap_xo_q  <= 1'b0;
			strap_fx_q  <= 1'b0;
			multi_q     <= 1'b0;
		end
		else if (strap_cnt_q != 2'h3)
		begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
			strap_neg_q <= pin_s[7];
			strap_xo_q  <= pin_s[6];
			strap_fx_q  <= pin_s[5];
			multi_q     <= pin_s[9];
		end
	end

	assign strap_neg_off   = strap_neg_q;
	assign strap_xover_off = strap_xo_q;
	assign strap_force_x   = strap_fx_q;
	assign multi_s         = multi_q;

	// ****************************************
	// Resolution helpers
	// ****************************************
	// Highest common technology, gigabit over 100 over 10, full over half
	function automatic logic [2:0] best_mode(input logic [15:0] loc,
		input logic [15:0] par, input logic gig);
		logic [15:0] c;
		c = loc & par;
		if (gig) best_mode = {SPD_1000, 1'b1};
		else if (c[8]) best_mode = {SPD_100, 1'b1};
		else if (c[7]) best_mode = {SPD_100, 1'b0};
		else if (c[6]) best_mode = {SPD_10, 1'b1};
		else if (c[5]) best_mode = {SPD_10, 1'b0};
		else best_mode = {SPD_NONE, 1'b0};
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	logic [15:0] control_q;
	logic [15:0] advert_q;
	logic [15:0] partner_q;
	logic [15:0] np_tx_q;
	logic [15:0] xcvr_q;
	logic        neg_complete_q;
	logic        partner_neg_q;
	logic        pd_fault_q;
	logic        restart_req;
	logic        neg_enabled;
	logic        wr_ctrl;

	assign wr_ctrl = reg_wr && reg_addr == REG_BASIC_CONTROL;
	assign neg_enabled = control_q[BIT_NEG_ENABLE] && !strap_neg_off;
	assign restart_req = control_q[BIT_RESTART];

	anx_state_type state_q;
	logic [31:0]   timer_q;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			control_q <= CONTROL_RESET;
		else if (wr_ctrl)
		begin
			control_q <= reg_wdata;
			if (strap_neg_off)
				control_q[BIT_NEG_ENABLE] <= 1'b0;
		end
		else if (strap_neg_off)
			control_q[BIT_NEG_ENABLE] <= 1'b0;
		else if (restart_req && state_q == ST_BREAK)
			control_q[BIT_RESTART] <= 1'b0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			advert_q <= ADVERT_RESET;
			np_tx_q  <= NEXT_PAGE_RESET;
			xcvr_q   <= XCVR_RESET;
		end
		else if (reg_wr)
		begin
			if (reg_addr == REG_LOCAL_ADVERT)
				advert_q <= reg_wdata;
			else if (reg_addr == REG_NEXT_PAGE_TX)
				np_tx_q <= reg_wdata;
			else if (reg_addr == REG_XCVR_CONTROL)
				xcvr_q <= reg_wdata;
		end
	end

	// ****************************************
	// Crossover
	// ****************************************
	logic xover_done;

	anx_xover #(.SLOT_CYC(SLOT_CYC)) u_xover (
		.sys_clk       (sys_clk),
		.rst_n         (rst_n),
		.auto_en       (xcvr_q[BIT_XOVER_AUTO] && !strap_xover_off),
		.force_crossed (xcvr_q[BIT_XOVER_FORCE] || strap_force_x),
		.energy_seen   (energy_s),
		.crossed       (pairs_crossed),
		.resolved      (xover_done)
	);

	// ****************************************
	// Negotiation sequencer
	// ****************************************
	logic       pd_link;
	logic [2:0] mode;

	assign pd_link = link10_s ^ link100_s;
	assign mode = best_mode(advert_q, page_s, 1'b0);

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			state_q        <= ST_DISABLED;
			timer_q        <= '0;
			neg_complete_q <= 1'b0;
			partner_neg_q  <= 1'b0;
			pd_fault_q     <= 1'b0;
			partner_q      <= '0;
			link_up        <= 1'b0;
			link_speed     <= SPD_NONE;
			full_duplex    <= 1'b0;
			gig_master     <= 1'b0;
		end
		else if (!neg_enabled)
		begin
			state_q        <= ST_DISABLED;
			neg_complete_q <= 1'b0;
			link_up        <= 1'b0;
		end
		else if (restart_req)
		begin
			state_q        <= ST_BREAK;
			timer_q        <= '0;
			neg_complete_q <= 1'b0;
			link_up        <= 1'b0;
		end
		else
		begin
			case (state_q)
				ST_DISABLED:
				begin
					state_q <= ST_BREAK;
					timer_q <= '0;
				end
				ST_BREAK:
				begin
					timer_q <= timer_q + 32'h1;
					if (timer_q >= 32'(BREAK_CYC - 1))
					begin
						state_q <= ST_XOVER;
						timer_q <= '0;
					end
				end
				ST_XOVER:
					if (xover_done)
						state_q <= ST_EXCHANGE;
				ST_EXCHANGE:
				begin
					timer_q <= timer_q + 32'h1;
					if (page_v_s && timer_q >= 32'(NEG_CYC - 1)
						&& !np_v_s)
					begin
						partner_q      <= page_s;
						partner_neg_q  <= 1'b1;
						neg_complete_q <= 1'b1;
						state_q        <= ST_LINK_UP;
						link_up        <= mode[2:1] != SPD_NONE;
						link_speed     <= anx_speed_type'(mode[2:1]);
						full_duplex    <= mode[0];
						gig_master     <= multi_s || seed_s;
					end
					else if (!page_v_s && pd_link
						&& timer_q >= 32'(NEG_CYC - 1))
					begin
						partner_q <= '0;
						partner_q[4:0] <= SELECTOR_8023;
						partner_q[BIT_PARTNER_10]  <= link10_s;
						partner_q[BIT_PARTNER_100] <= link100_s;
						partner_neg_q  <= 1'b0;
						neg_complete_q <= 1'b1;
						state_q        <= ST_LINK_UP;
						link_up        <= 1'b1;
						link_speed     <= link100_s ? SPD_100 : SPD_10;
						full_duplex    <= 1'b0;
					end
					else if (!page_v_s && link10_s && link100_s)
						pd_fault_q <= 1'b1;
				end
				ST_LINK_UP:
					if (!(link10_s || link100_s || page_v_s))
					begin
						state_q        <= ST_BREAK;
						timer_q        <= '0;
						neg_complete_q <= 1'b0;
						link_up        <= 1'b0;
					end
				default:
					state_q <= ST_DISABLED;
			endcase
			// Fault clears on read while negotiation is enabled and no restart is pending, a new fault in the same cycle wins
			if (reg_rd && reg_addr == REG_EXPANSION
				&& !(state_q == ST_EXCHANGE && link10_s && link100_s))
				pd_fault_q <= 1'b0;
		end
	end

	// ****************************************
	// Transmit control
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			tx_quiet <= 1'b1;
			flp_send <= 1'b0;
			flp_page <= '0;
		end
		else
		begin
			tx_quiet <= state_q == ST_BREAK || state_q == ST_XOVER;
			flp_send <= state_q == ST_EXCHANGE;
			flp_page <= np_v_s ? np_tx_q : advert_q;
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			reg_rdata <= '0;
		else if (reg_rd)
		begin
			if (reg_addr == REG_BASIC_CONTROL)
				reg_rdata <= control_q;
			else if (reg_addr == REG_BASIC_STATUS)
			begin
				reg_rdata <= STATUS_ABILITY;
				reg_rdata[BIT_NEG_COMPLETE] <= neg_complete_q;
				reg_rdata[BIT_LINK_STATUS]  <= link_up;
			end
			else if (reg_addr == REG_LOCAL_ADVERT)
				reg_rdata <= advert_q;
			else if (reg_addr == REG_PARTNER_AB)
				reg_rdata <= partner_q;
			else if (reg_addr == REG_EXPANSION)
			begin
				reg_rdata <= '0;
				reg_rdata[BIT_PARTNER_NEG] <= partner_neg_q;
				reg_rdata[BIT_PD_FAULT]    <= pd_fault_q;
			end
			else if (reg_addr == REG_NEXT_PAGE_TX)
				reg_rdata <= np_tx_q;
			else if (reg_addr == REG_XCVR_CONTROL)
				reg_rdata <= xcvr_q;
			else
				reg_rdata <= '0;
		end
	end
endmodule
`default_nettype wire

// *** tb/anx_core_asserts.sv ***
// Port-level checker for the negotiation core
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Checker
// ****************************************
module anx_core_asserts
	import anx_pkg::*;
(
	input wire logic          sys_clk,
	input wire logic          rst_n,
	input wire logic          reg_wr,
	input wire logic          reg_rd,
	input wire logic [4:0]    reg_addr,
	input wire logic [15:0]   reg_wdata,
	input wire logic [15:0]   reg_rdata,
	input wire logic          neg_disable_strap,
	input wire logic          crossover_disable_strap,
	input wire logic          forced_pair_select_strap,
	input wire logic          tx_quiet,
	input wire logic          flp_send,
	input wire logic          pairs_crossed,
	input wire logic          link_up,
	input wire anx_speed_type link_speed
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	property p_quiet_no_flp;
		tx_quiet |-> !flp_send;
	endproperty
	a_quiet_no_flp: assert property (p_quiet_no_flp)
		else $error("pulses sent while quiet");
	property p_restart;
		reg_wr && reg_addr == REG_BASIC_CONTROL && reg_wdata[BIT_RESTART]
			&& reg_wdata[BIT_NEG_ENABLE] && !neg_disable_strap
			|-> ##[1:3] tx_quiet;
	endproperty
	a_restart: assert property (p_restart)
		else $error("restart did not silence the line");
	property p_link_tx;
		link_up |-> !tx_quiet;
	endproperty
	a_link_tx: assert property (p_link_tx)
		else $error("quiet while link up");
	property p_speed;
		$rose(link_up) |-> link_speed != SPD_NONE;
	endproperty
	a_speed: assert property (p_speed)
		else $error("link up without speed");
	property p_complete;
		reg_rd && reg_addr == REG_BASIC_STATUS && link_up ##1 link_up
			|-> reg_rdata[BIT_NEG_COMPLETE];
	endproperty
	a_complete: assert property (p_complete)
		else $error("complete flag low with link up");
	property p_strap;
		reg_rd && reg_addr == REG_BASIC_CONTROL && neg_disable_strap
			|=> !reg_rdata[BIT_NEG_ENABLE];
	endproperty
	a_strap: assert property (p_strap)
		else $error("enable bit set under strap");
	property p_forced;
		crossover_disable_strap && forced_pair_select_strap [*8]
			|-> ##3 pairs_crossed;
	endproperty
	a_forced: assert property (p_forced)
		else $error("forced crossed pairs not applied");
	property p_relink;
		$fell(link_up) && !$past(reg_wr) |-> ##[0:3] (tx_quiet || flp_send);
	endproperty
	a_relink: assert property (p_relink)
		else $error("negotiation not resumed after loss");
	c_link: cover property ($rose(link_up));
	c_quiet: cover property ($rose(tx_quiet));
	c_flp: cover property ($rose(flp_send));
endmodule

bind anx_core anx_core_asserts i_anx_core_asserts (
	.sys_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
	.neg_disable_strap, .crossover_disable_strap, .forced_pair_select_strap,
	.tx_quiet, .flp_send, .pairs_crossed, .link_up, .link_speed
);
`default_nettype wire

// *** tb/anx_partner_model.sv ***
// Behavioural link partner on the cable side
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Partner model
// ****************************************
module anx_partner_model
(
	input  wire logic [2:0] mode,
	input  wire logic       sys_clk,
	input  wire logic       tx_quiet,
	output logic            page_valid,
	output logic [15:0]     page,
	output logic            master_seed,
	output logic            link_10,
	output logic            link_100,
	output logic            energy,
	output logic            np_valid
);
	// Modes: 0 gone, 1 negotiates, 2/3 legacy 10/100, 4 both, 5 next pages
	logic talk;
	logic neg;
	assign talk = mode != 3'h0 && !tx_quiet;
	assign neg = talk && (mode == 3'h1 || mode == 3'h5);
	initial page = 16'h5a5a;
	always @(posedge sys_clk)
	begin
		// Partner keeps pulsing while we are quiet, so crossover can lock
		energy <= mode != 3'h0;
		page_valid <= neg;
		// Released page toggles so a stale value is never mistaken for data
		page <= neg ? 16'h0de1 : ~page;
		np_valid <= talk && mode == 3'h5;
		link_10 <= talk && (mode == 3'h2 || mode == 3'h4);
		link_100 <= talk && (mode == 3'h3 || mode == 3'h4);
		master_seed <= 1'b0;
	end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the negotiation core
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bench
// ****************************************
module tb_top;
	import anx_pkg::*;
	logic          sys_clk, rst_n, reg_wr, reg_rd;
	logic [4:0]    reg_addr;
	logic [15:0]   reg_wdata, reg_rdata, pg, flp_page;
	logic          s_neg, s_xo, s_fp, pv, seed, l10, l100, en, npv, multi;
	logic          tx_quiet, flp_send, pairs_crossed, link_up, fd, gm;
	anx_speed_type link_speed;
	logic [2:0]    mode;
	int            fail_count, tests_run, cyc;

	anx_core #(.BREAK_CYC(20), .NEG_CYC(50), .SLOT_CYC(8)) i_anx_core (
		.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.neg_disable_strap(s_neg), .crossover_disable_strap(s_xo),
		.forced_pair_select_strap(s_fp), .multiport_node(multi),
		.partner_page_valid(pv), .partner_page(pg),
		.partner_master_seed(seed), .rx_link_10(l10), .rx_link_100(l100),
		.rx_energy(en), .partner_np_valid(npv), .tx_quiet(tx_quiet),
		.flp_send(flp_send), .flp_page(flp_page),
		.pairs_crossed(pairs_crossed), .link_up(link_up),
		.link_speed(link_speed), .full_duplex(fd), .gig_master(gm));
	anx_partner_model i_anx_partner_model (.mode(mode), .sys_clk(sys_clk),
		.tx_quiet(tx_quiet), .page_valid(pv), .page(pg),
		.master_seed(seed), .link_10(l10), .link_100(l100), .energy(en),
		.np_valid(npv));

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rchk(input string n, input logic [4:0] a,
		input logic [15:0] m, input logic [15:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		chk(n, reg_rdata & m, e);
	endtask
	// Bounded wait; the caller compares the outcome
	task automatic wait_sig(input logic e, input logic which);
		int i;
		i = 0;
		while ((which ? flp_send : link_up) !== e && i < 1000)
		begin
			@(posedge sys_clk);
			i++;
		end
	endtask

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			results();
		end
	end

	initial
	begin
		{rst_n, reg_wr, reg_rd, s_neg, s_xo, s_fp} = 6'h00;
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
		multi = 1'b1;
		mode = 3'h0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rchk("control", REG_BASIC_CONTROL, 16'hffff, CONTROL_RESET);
		rchk("advert", REG_LOCAL_ADVERT, 16'hffff, ADVERT_RESET);
		rchk("next page", REG_NEXT_PAGE_TX, 16'hffff, NEXT_PAGE_RESET);
		rchk("xcvr", REG_XCVR_CONTROL, 16'hffff, XCVR_RESET);
		rchk("unmapped", 5'h02, 16'hffff, 16'h0000);
		wr(REG_BASIC_STATUS, 16'h0000);
		rchk("status", REG_BASIC_STATUS, 16'hffc0, STATUS_ABILITY & 16'hffc0);
		wr(REG_LOCAL_ADVERT, 16'h0de1);
		wr(REG_NEXT_PAGE_TX, 16'h2abc);
		rchk("next page", REG_NEXT_PAGE_TX, 16'hffff, 16'h2abc);
		$display("test registers done");
		mode <= 3'h1;
		wr(REG_BASIC_CONTROL, 16'h1200);
		@(posedge sys_clk);
		rchk("restart bit", REG_BASIC_CONTROL, 16'h0200, 16'h0000);
		wait_sig(1'b1, 1'b1);
		chk("flp page", flp_page, 16'h0de1);
		wait_sig(1'b1, 1'b0);
		chk("link", {15'h0, link_up}, 16'h0001);
		chk("speed", {14'h0, link_speed}, {14'h0, SPD_100});
		chk("duplex", {15'h0, fd}, 16'h0001);
		chk("master", {15'h0, gm}, 16'h0001);
		rchk("partner", REG_PARTNER_AB, 16'hffff, 16'h0de1);
		rchk("negotiable", REG_EXPANSION, 16'h0001, 16'h0001);
		$display("test negotiate done");
		mode <= 3'h0;
		wait_sig(1'b0, 1'b0);
		chk("link lost", {15'h0, link_up}, 16'h0000);
		mode <= 3'h1;
		wait_sig(1'b1, 1'b0);
		chk("relink", {15'h0, link_up}, 16'h0001);
		$display("test relink done");
		mode <= 3'h5;
		wr(REG_BASIC_CONTROL, 16'h1200);
		repeat (200) @(posedge sys_clk);
		chk("np deferred", {15'h0, link_up}, 16'h0000);
		chk("np page", flp_page, 16'h2abc);
		mode <= 3'h1;
		wait_sig(1'b1, 1'b0);
		chk("np done", {15'h0, link_up}, 16'h0001);
		$display("test next page done");
		mode <= 3'h2;
		wr(REG_BASIC_CONTROL, 16'h1200);
		wait_sig(1'b0, 1'b0);
		wait_sig(1'b1, 1'b0);
		chk("pd speed", {14'h0, link_speed}, {14'h0, SPD_10});
		chk("pd duplex", {15'h0, fd}, 16'h0000);
		rchk("pd partner", REG_PARTNER_AB, 16'h00bf, 16'h0021);
		rchk("pd negotiable", REG_EXPANSION, 16'h0001, 16'h0000);
		rchk("pd complete", REG_BASIC_STATUS, 16'h0020, 16'h0020);
		mode <= 3'h4;
		wr(REG_BASIC_CONTROL, 16'h1200);
		repeat (300) @(posedge sys_clk);
		rchk("pd fault", REG_EXPANSION, 16'h0010, 16'h0010);
		$display("test parallel detect done");
		mode <= 3'h0;
		wait_sig(1'b0, 1'b0);
		wr(REG_BASIC_CONTROL, 16'h0000);
		rchk("disabled", REG_BASIC_CONTROL, 16'h1000, 16'h0000);
		wr(REG_BASIC_CONTROL, 16'h1000);
		rchk("enabled", REG_BASIC_CONTROL, 16'h1000, 16'h1000);
		rchk("fault held", REG_EXPANSION, 16'h0010, 16'h0010);
		rchk("fault cleared", REG_EXPANSION, 16'h0010, 16'h0000);
		wr(REG_XCVR_CONTROL, 16'h0020);
		repeat (5) @(posedge sys_clk);
		chk("forced x", {15'h0, pairs_crossed}, 16'h0001);
		wr(REG_XCVR_CONTROL, 16'h0000);
		repeat (5) @(posedge sys_clk);
		chk("forced s", {15'h0, pairs_crossed}, 16'h0000);
		$display("test crossover done");
		rst_n <= 1'b0;
		{s_neg, s_xo, s_fp} <= 3'h7;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (12) @(posedge sys_clk);
		chk("strap x", {15'h0, pairs_crossed}, 16'h0001);
		wr(REG_BASIC_CONTROL, 16'h1000);
		rchk("strap neg", REG_BASIC_CONTROL, 16'h1000, 16'h0000);
		$display("test straps done");
		results();
	end
endmodule
`default_nettype wire
